// [design/sfpe_device.sv]
// flash device end: quad read, page program, sector/block erase, write latch and busy
`default_nettype none
module sfpe_device
  import sfpe_pkg::*;
#(
  parameter int MEM_AW = 20
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic QPI_MODE,
  input wire logic QUAD_ENABLE,
  input wire logic [3:0] BLOCK_PROTECT,
  input wire logic [3:0] DUMMY_CYCLES,
  output logic BUSY,
  output logic WRITE_ENABLE_LATCH,
  sfpe_if.dev LINK
);
  initial begin
    if (MEM_AW < BLK64_AW + 1 || MEM_AW > 24) $error("MEM_AW must lie in 17..24");
  end

  typedef enum logic [2:0] {
    F_OPC = 3'h0,
    F_ADDR = 3'h1,
    F_MODE = 3'h2,
    F_DUMMY = 3'h3,
    F_READ = 3'h4,
    F_DATA = 3'h5,
    F_TAIL = 3'h6,
    F_IGN = 3'h7
  } sfpe_frame_type;

  logic [7:0] mem_q [2**MEM_AW];
  logic [7:0] pbuf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pval_q;

  // ---------------- link clock domain ----------------
  logic fr_rst;
  logic fresh_q;
  logic qpi_s1_q, qpi_q, bsy_s1_q, bsy_q;
  logic [3:0] dum_s1_q, dum_q;
  sfpe_frame_type state_q, st;
  logic [4:0] cnt_q, cnt;
  logic [7:0] sh_q, sh_nx, cmd_q;
  logic [23:0] addr_q, addr_nx;
  logic [7:0] idx_q;
  logic ok_q, cr_q, wide, byte_end;
  logic [4:0] alast;
  logic nib_q;
  logic [MEM_AW-1:0] rd_off_q;
  logic [7:0] rd_byte;
  logic [3:0] dout_q, doe_q;
  logic busy_q, wel_q;

  assign fr_rst = LINK.cs_n | ~NRST;

  // set while select is high; the first clock edge of a frame sees it
  always_ff @(posedge LINK.sck or posedge fr_rst) begin
    if (fr_rst) fresh_q <= 1'b1;
    else fresh_q <= 1'b0;
  end

  always_ff @(posedge LINK.sck or negedge NRST) begin
    if (!NRST) begin
      bsy_s1_q <= 1'b0;
      bsy_q <= 1'b0;
      dum_s1_q <= 4'h0;
      dum_q <= 4'h0;
    end else begin
      bsy_s1_q <= busy_q;
      bsy_q <= bsy_s1_q;
      dum_s1_q <= DUMMY_CYCLES;
      dum_q <= dum_s1_q;
    end
  end

  assign st = fresh_q ? F_OPC : state_q; // [RULE_05]
  assign cnt = fresh_q ? 5'h00 : cnt_q;
  assign wide = (st == F_OPC) ? qpi_q : (qpi_q | sfpe_quad_cmd(cmd_q)); // [RULE_01] [RULE_02] [RULE_16]
  assign sh_nx = wide ? {sh_q[3:0], LINK.io} : {sh_q[6:0], LINK.io[0]};
  assign addr_nx = wide ? {addr_q[19:0], LINK.io} : {addr_q[22:0], LINK.io[0]};
  assign byte_end = wide ? cnt[0] : (cnt[2:0] == 3'h7);
  assign alast = (wide ? QUAD_ADDR_CLKS : SERIAL_ADDR_CLKS) - 5'h01;

  always_ff @(posedge LINK.sck or negedge NRST) begin
    if (!NRST) begin
      state_q <= F_OPC;
      cnt_q <= 5'h00;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      addr_q <= 24'h000000;
      idx_q <= 8'h00;
      ok_q <= 1'b0;
      cr_q <= 1'b0;
      pval_q <= '0;
    end else begin
      sh_q <= sh_nx;
      cnt_q <= cnt + 5'h01;
      unique case (st)
        F_OPC: begin
          ok_q <= 1'b0;
          if (fresh_q && cr_q) begin
            // continuous read: this frame starts straight at the address
            cmd_q <= QUAD_IO_FAST_READ;
            addr_q <= {addr_q[19:0], LINK.io};
            state_q <= F_ADDR; // [RULE_04]
          end else if (byte_end) begin
            cmd_q <= sh_nx;
            cnt_q <= 5'h00;
            if (sh_nx == WRITE_ENABLE_CMD) begin
              ok_q <= 1'b1; // [RULE_22]
              state_q <= F_TAIL;
            end else if (sh_nx == QUAD_IO_FAST_READ || sfpe_prog_cmd(sh_nx) || sfpe_erase_cmd(sh_nx)) begin
              state_q <= F_ADDR;
            end else state_q <= F_IGN;
          end else state_q <= F_OPC;
        end
        F_ADDR: begin
          addr_q <= addr_nx;
          if (cnt == alast) begin
            cnt_q <= 5'h00;
            idx_q <= addr_nx[7:0];
            // the busy copy is stale on a frame's first two clocks, current here
            if (bsy_q) state_q <= F_IGN; // [RULE_07] [RULE_12] [RULE_21]
            else if (cmd_q == QUAD_IO_FAST_READ) state_q <= F_MODE;
            else if (sfpe_prog_cmd(cmd_q)) begin
              state_q <= F_DATA;
              pval_q <= '0;
            end else begin
              ok_q <= 1'b1; // [RULE_18] [RULE_20]
              state_q <= F_TAIL;
            end
          end
        end
        F_MODE: begin
          if (cnt == MODE_CLKS - 5'h01) begin
            cr_q <= (sh_nx[7:4] == CONT_READ_NIBBLE); // [RULE_03] [RULE_04]
            cnt_q <= 5'h00;
            state_q <= ({1'b0, dum_q} > MODE_CLKS) ? F_DUMMY : F_READ; // [RULE_06]
          end
        end
        F_DUMMY: begin
          if (cnt + MODE_CLKS + 5'h01 >= {1'b0, dum_q}) state_q <= F_READ; // [RULE_06]
        end
        F_READ: state_q <= F_READ;
        F_DATA: begin
          ok_q <= byte_end; // [RULE_11]
          if (byte_end) begin
            cnt_q <= 5'h00;
            pval_q[idx_q] <= 1'b1;
            idx_q <= idx_q + 8'h01; // [RULE_13]
          end
        end
        F_TAIL: begin
          ok_q <= 1'b0;
          state_q <= F_TAIL;
        end
        F_IGN: state_q <= F_IGN;
      endcase
    end
  end

  // page buffer keeps the last byte written to each slot
  always_ff @(posedge LINK.sck) begin
    if (st == F_DATA && byte_end) pbuf_q[idx_q] <= sh_nx; // [RULE_13]
  end

  assign rd_byte = mem_q[addr_q[MEM_AW-1:0] + rd_off_q];

  // read data leaves on the falling edge, high nibble first
  always_ff @(negedge LINK.sck or posedge fr_rst) begin
    if (fr_rst) begin
      nib_q <= 1'b0;
      rd_off_q <= '0;
      dout_q <= 4'h0;
      doe_q <= 4'h0;
    end else if (state_q == F_READ && !fresh_q) begin
      doe_q <= 4'hF; // [RULE_02]
      dout_q <= nib_q ? rd_byte[3:0] : rd_byte[7:4];
      nib_q <= ~nib_q;
      if (nib_q) rd_off_q <= rd_off_q + MEM_AW'(1);
    end
  end

  assign LINK.d_io_o = dout_q;
  assign LINK.d_io_oe = doe_q;

  // ---------------- core clock domain ----------------
  logic cs_s1_q, cs_s2_q, cs_s3_q, take;
  logic prog_q;
  logic [MEM_AW-1:0] wbase_q;
  logic [15:0] wcnt_q, wlast_q;
  logic [MEM_AW-1:0] widx;

  function automatic logic prot_f(input logic [MEM_AW-1:0] a, input logic [3:0] bp);
    logic [MEM_AW-BLK64_AW-1:0] m;
    m = ~({(MEM_AW - BLK64_AW){1'b1}} << (bp - 4'h1));
    return (bp != 4'h0) && (&(a[MEM_AW-1:BLK64_AW] | m));
  endfunction : prot_f

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      qpi_s1_q <= 1'b0;
      qpi_q <= 1'b0;
    end else begin
      cs_s1_q <= LINK.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      qpi_s1_q <= QPI_MODE; // static level, settled before the first link clock after reset
      qpi_q <= qpi_s1_q;
    end
  end

  // frame fields are static once select is high and the link clock stops
  assign take = cs_s2_q & ~cs_s3_q & ~busy_q & ok_q; // [RULE_11] [RULE_12] [RULE_21]
  assign widx = wbase_q + MEM_AW'(wcnt_q);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      busy_q <= 1'b0;
      wel_q <= 1'b0;
      prog_q <= 1'b0;
      wbase_q <= '0;
      wcnt_q <= 16'h0000;
      wlast_q <= 16'h0000;
    end else if (busy_q) begin
      wcnt_q <= wcnt_q + 16'h0001;
      if (wcnt_q == wlast_q) begin
        busy_q <= 1'b0; // [RULE_12] [RULE_21]
        wel_q <= 1'b0; // [RULE_19]
        wcnt_q <= 16'h0000;
      end
    end else if (take) begin
      if (cmd_q == WRITE_ENABLE_CMD) wel_q <= 1'b1; // [RULE_22]
      else if (wel_q && !prot_f(addr_q[MEM_AW-1:0], BLOCK_PROTECT)) begin // [RULE_09]
        if (sfpe_prog_cmd(cmd_q) && (cmd_q == PAGE_PROGRAM_CMD || QUAD_ENABLE)) begin
          busy_q <= 1'b1;
          prog_q <= 1'b1;
          wbase_q <= addr_q[MEM_AW-1:0] & ~MEM_AW'(PAGE_LAST);
          wlast_q <= PAGE_LAST;
        end else if (sfpe_erase_cmd(cmd_q)) begin
          busy_q <= 1'b1;
          prog_q <= 1'b0;
          wbase_q <= addr_q[MEM_AW-1:0] & ~MEM_AW'(sfpe_unit_last(cmd_q)); // [RULE_23]
          wlast_q <= sfpe_unit_last(cmd_q); // [RULE_17]
        end
      end
    end
  end

  // array update, one byte per core clock
  always_ff @(posedge CLOCK) begin
    if (busy_q) begin
      if (!prog_q) mem_q[widx] <= ERASED_BYTE; // [RULE_17]
      else if (pval_q[wcnt_q[7:0]]) mem_q[widx] <= mem_q[widx] & pbuf_q[wcnt_q[7:0]]; // [RULE_13] [RULE_14]
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      BUSY <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
    end else begin
      BUSY <= busy_q;
      WRITE_ENABLE_LATCH <= wel_q;
    end
  end
endmodule : sfpe_device
`default_nettype wire

// [design/sfpe_pkg.sv]
// shared constants, types and decode functions for the serial flash program/erase link
// Operation
// [RULE_01] quad read opcode: two quad or eight serial clocks
// [RULE_02] quad read address and data on four lines
// [RULE_03] host gives mode byte in first two dummy clocks
// [RULE_04] upper nibble Ah enters continuous read, else leaves
// [RULE_05] after read, ready again, protocol mode kept
// [RULE_06] dummy count includes the two mode clocks
// [RULE_07] quad read ignored while busy
// [RULE_08] serial program: opcode, address, 1..256 bytes
// [RULE_09] program into protected region is ignored
// [RULE_10] host sets write latch before program or erase
// [RULE_11] program starts on chip select rise, else dropped
// [RULE_12] busy while programming, other commands ignored
// [RULE_13] over 256 bytes wraps in page, last kept
// [RULE_14] program only clears bits, erase sets them
// [RULE_15] host sets quad enable before quad program
// [RULE_16] quad program: opcode, address, data on four lines
// [RULE_17] erase sets 4K sector or 32K/64K block to ones
// [RULE_18] sector erase: select low, starts on rise
// [RULE_19] write latch cleared when erase completes
// [RULE_20] two block erase opcodes, run on proper rise
// [RULE_21] busy while erasing, other commands ignored
// [RULE_22] write enable command sets the write latch
// [RULE_23] erase whole aligned unit holding the address
`default_nettype none
package sfpe_pkg;
  localparam logic [7:0] QUAD_IO_FAST_READ = 8'hEB;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] QUAD_INPUT_PROGRAM_CMD = 8'h32;
  localparam logic [7:0] QUAD_INPUT_PROGRAM_ALT = 8'h38;
  localparam logic [7:0] ERASE_SMALL_UNIT_CMD = 8'hD7;
  localparam logic [7:0] ERASE_SMALL_UNIT_ALT = 8'h20;
  localparam logic [7:0] BLOCK_ERASE_SMALL_CMD = 8'h52;
  localparam logic [7:0] BLOCK_ERASE_LARGE_CMD = 8'hD8;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] CONT_READ_NIBBLE = 4'hA;
  localparam logic [4:0] QUAD_OPC_CLKS = 5'h02;
  localparam logic [4:0] SERIAL_OPC_CLKS = 5'h08;
  localparam logic [4:0] QUAD_ADDR_CLKS = 5'h06;
  localparam logic [4:0] SERIAL_ADDR_CLKS = 5'h18;
  localparam logic [4:0] MODE_CLKS = 5'h02;
  localparam logic [15:0] SECTOR_LAST = 16'h0FFF;
  localparam logic [15:0] BLK32_LAST = 16'h7FFF;
  localparam logic [15:0] BLK64_LAST = 16'hFFFF;
  localparam logic [15:0] PAGE_LAST = 16'h00FF;
  localparam int PAGE_BYTES = 256;
  localparam int BLK64_AW = 16;
  localparam logic [4:0] GAP_CYCLES = 5'h04;

  typedef enum logic [2:0] {
    SFPE_OP_READ = 3'h0,
    SFPE_OP_PROG = 3'h1,
    SFPE_OP_QPROG = 3'h2,
    SFPE_OP_ERASE4 = 3'h3,
    SFPE_OP_ERASE32 = 3'h4,
    SFPE_OP_ERASE64 = 3'h5,
    SFPE_OP_WRITE_ENABLE_CMD = 3'h6
  } sfpe_op_type;

  function automatic logic sfpe_quad_cmd(input logic [7:0] c);
    return c == QUAD_IO_FAST_READ || c == QUAD_INPUT_PROGRAM_CMD || c == QUAD_INPUT_PROGRAM_ALT;
  endfunction : sfpe_quad_cmd

  function automatic logic sfpe_prog_cmd(input logic [7:0] c);
    return c == PAGE_PROGRAM_CMD || c == QUAD_INPUT_PROGRAM_CMD || c == QUAD_INPUT_PROGRAM_ALT;
  endfunction : sfpe_prog_cmd

  function automatic logic sfpe_erase_cmd(input logic [7:0] c);
    return c == ERASE_SMALL_UNIT_CMD || c == ERASE_SMALL_UNIT_ALT || c == BLOCK_ERASE_SMALL_CMD ||
           c == BLOCK_ERASE_LARGE_CMD;
  endfunction : sfpe_erase_cmd

  function automatic logic [15:0] sfpe_unit_last(input logic [7:0] c);
    if (c == BLOCK_ERASE_LARGE_CMD) return BLK64_LAST;
    if (c == BLOCK_ERASE_SMALL_CMD) return BLK32_LAST;
    return SECTOR_LAST;
  endfunction : sfpe_unit_last
endpackage : sfpe_pkg
`default_nettype wire

// [design/sfpe_if.sv]
// link between flash host controller and flash device: clock, select, four data lines
`default_nettype none
interface sfpe_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;
  // resolved line level, weak pull-up when nobody drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = h_io_oe[i] ? h_io_o[i] : (d_io_oe[i] ? d_io_o[i] : 1'b1);
    end
  end
  modport dev (input sck, input cs_n, input io, output d_io_o, output d_io_oe);
  modport host (output sck, output cs_n, output h_io_o, output h_io_oe, input io);
endinterface : sfpe_if
`default_nettype wire

// [design/sfpe_host.sv]
// flash host controller end: makes the link clock and sequences one command per request
`default_nettype none
module sfpe_host
  import sfpe_pkg::*;
#(
  parameter int SCK_DIV = 2
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic QPI_MODE,
  input wire logic [3:0] DUMMY_CYCLES,
  input wire logic REQ,
  input wire sfpe_op_type REQ_OP,
  input wire logic [23:0] REQ_ADDR,
  input wire logic [8:0] REQ_LEN,
  input wire logic [7:0] REQ_MODE,
  input wire logic REQ_SKIP_OPC,
  input wire logic [7:0] WR_DATA,
  output logic WR_TAKE,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic BUSY,
  output logic DONE,
  sfpe_if.host LINK
);
  initial begin
    if (SCK_DIV < 2 || SCK_DIV > 8) $error("SCK_DIV must lie in 2..8");
  end

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_CMD = 3'h1,
    H_ADDR = 3'h2,
    H_MODE = 3'h3,
    H_DUMMY = 3'h4,
    H_WR = 3'h5,
    H_RD = 3'h6,
    H_GAP = 3'h7
  } sfpe_hstate_type;

  localparam logic [3:0] DIV_LAST = 4'(2 * SCK_DIV - 1);
  localparam logic [3:0] DIV_HIGH = 4'(SCK_DIV);

  sfpe_hstate_type ph_q;
  sfpe_op_type op_q;
  logic [3:0] div_q, io_s1_q, io_s2_q, rd_sh_q;
  logic [31:0] sh_q;
  logic [4:0] left_q;
  logic [8:0] bytes_q;
  logic wide_q, nib_q, cs_n_q, sck_q, edge_end;
  logic [3:0] ho_q, hoe_q;

  function automatic logic [7:0] opc_f(input sfpe_op_type o);
    unique case (o)
      SFPE_OP_READ: return QUAD_IO_FAST_READ;
      SFPE_OP_PROG: return PAGE_PROGRAM_CMD;
      SFPE_OP_QPROG: return QUAD_INPUT_PROGRAM_CMD;
      SFPE_OP_ERASE4: return ERASE_SMALL_UNIT_CMD;
      SFPE_OP_ERASE32: return BLOCK_ERASE_SMALL_CMD; // [RULE_20]
      SFPE_OP_ERASE64: return BLOCK_ERASE_LARGE_CMD; // [RULE_20]
      SFPE_OP_WRITE_ENABLE_CMD: return WRITE_ENABLE_CMD;
    endcase
  endfunction : opc_f

  // addresses and data go on four lines for quad read and quad program
  function automatic logic quad_f(input sfpe_op_type o, input logic q);
    return q || o == SFPE_OP_READ || o == SFPE_OP_QPROG; // [RULE_02] [RULE_16]
  endfunction : quad_f

  assign edge_end = (div_q == DIV_LAST);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      io_s1_q <= LINK.io;
      io_s2_q <= io_s1_q;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ph_q <= H_IDLE;
      op_q <= SFPE_OP_READ;
      div_q <= 4'h0;
      sh_q <= 32'h0;
      left_q <= 5'h00;
      bytes_q <= 9'h000;
      wide_q <= 1'b0;
      nib_q <= 1'b0;
      rd_sh_q <= 4'h0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      WR_TAKE <= 1'b0;
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end else begin
      WR_TAKE <= 1'b0;
      RD_VALID <= 1'b0;
      DONE <= 1'b0;
      if (ph_q != H_IDLE && ph_q != H_GAP) begin
        div_q <= edge_end ? 4'h0 : div_q + 4'h1;
        sck_q <= !edge_end && (div_q + 4'h1 >= DIV_HIGH);
      end
      unique case (ph_q)
        H_IDLE: begin
          if (REQ) begin
            op_q <= REQ_OP;
            bytes_q <= REQ_LEN;
            BUSY <= 1'b1;
            cs_n_q <= 1'b0; // [RULE_18]
            div_q <= 4'h0;
            nib_q <= 1'b0;
            if (REQ_OP == SFPE_OP_READ && REQ_SKIP_OPC) begin
              ph_q <= H_ADDR;
              wide_q <= 1'b1;
              sh_q <= {REQ_ADDR, 8'h00};
              left_q <= QUAD_ADDR_CLKS;
            end else begin
              ph_q <= H_CMD;
              wide_q <= QPI_MODE;
              sh_q <= {opc_f(REQ_OP), 24'h0};
              left_q <= QPI_MODE ? QUAD_OPC_CLKS : SERIAL_OPC_CLKS; // [RULE_01]
            end
          end
        end
        H_GAP: begin
          div_q <= div_q + 4'h1;
          if ({1'b0, div_q} == GAP_CYCLES) begin
            ph_q <= H_IDLE;
            BUSY <= 1'b0;
            DONE <= 1'b1;
          end
        end
        default: begin
          if (edge_end) begin
            sh_q <= wide_q ? {sh_q[27:0], 4'h0} : {sh_q[30:0], 1'b0};
            left_q <= left_q - 5'h01;
            if (ph_q == H_RD) begin
              rd_sh_q <= io_s2_q;
              nib_q <= ~nib_q;
              if (nib_q) begin
                RD_DATA <= {rd_sh_q, io_s2_q}; // [RULE_02]
                RD_VALID <= 1'b1;
                bytes_q <= bytes_q - 9'h001;
              end
            end
            if (left_q == 5'h01) begin
              unique case (ph_q)
                H_CMD: begin
                  if (op_q == SFPE_OP_WRITE_ENABLE_CMD) begin
                    ph_q <= H_GAP;
                  end else begin
                    ph_q <= H_ADDR;
                    wide_q <= quad_f(op_q, QPI_MODE);
                    sh_q <= {REQ_ADDR, 8'h00};
                    left_q <= quad_f(op_q, QPI_MODE) ? QUAD_ADDR_CLKS : SERIAL_ADDR_CLKS;
                  end
                end
                H_ADDR: begin
                  if (op_q == SFPE_OP_READ) begin
                    ph_q <= H_MODE;
                    sh_q <= {REQ_MODE, 24'h0}; // [RULE_03]
                    left_q <= MODE_CLKS;
                  end else if (op_q == SFPE_OP_PROG || op_q == SFPE_OP_QPROG) begin
                    ph_q <= H_WR; // [RULE_08] [RULE_16]
                    sh_q <= {WR_DATA, 24'h0};
                    WR_TAKE <= 1'b1;
                    left_q <= wide_q ? QUAD_OPC_CLKS : SERIAL_OPC_CLKS;
                  end else ph_q <= H_GAP; // [RULE_18]
                end
                H_MODE: begin
                  if ({1'b0, DUMMY_CYCLES} > MODE_CLKS) begin
                    ph_q <= H_DUMMY;
                    left_q <= {1'b0, DUMMY_CYCLES} - MODE_CLKS;
                  end else begin
                    ph_q <= H_RD;
                    left_q <= 5'h1F;
                  end
                end
                H_DUMMY: begin
                  ph_q <= H_RD;
                  left_q <= 5'h1F;
                end
                H_WR: begin
                  if (bytes_q > 9'h001) begin
                    bytes_q <= bytes_q - 9'h001;
                    sh_q <= {WR_DATA, 24'h0};
                    WR_TAKE <= 1'b1;
                    left_q <= wide_q ? QUAD_OPC_CLKS : SERIAL_OPC_CLKS;
                  end else ph_q <= H_GAP; // [RULE_11]
                end
                default: ph_q <= ph_q;
              endcase
            end
            if (ph_q == H_RD) left_q <= 5'h1F;
            if (ph_q == H_RD && nib_q && bytes_q == 9'h001) ph_q <= H_GAP;
            if (left_q == 5'h01 && ph_q != H_RD || ph_q == H_RD && nib_q && bytes_q == 9'h001) begin
              if (ph_q == H_CMD && op_q == SFPE_OP_WRITE_ENABLE_CMD || ph_q == H_ADDR && op_q > SFPE_OP_QPROG ||
                  ph_q == H_WR && bytes_q <= 9'h001 || ph_q == H_RD) begin
                cs_n_q <= 1'b1; // [RULE_11] [RULE_18] [RULE_20]
                div_q <= 4'h0;
                sck_q <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  // line drive follows the shifted data one core clock after the falling clock edge
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ho_q <= 4'h0;
      hoe_q <= 4'h0;
    end else if (ph_q == H_IDLE || ph_q == H_GAP || ph_q == H_DUMMY || ph_q == H_RD || cs_n_q) begin
      hoe_q <= 4'h0;
    end else begin
      hoe_q <= wide_q ? 4'hF : 4'h1;
      ho_q <= wide_q ? sh_q[31:28] : {3'h0, sh_q[31]};
    end
  end

  assign LINK.sck = sck_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.h_io_o = ho_q;
  assign LINK.h_io_oe = hoe_q;
endmodule : sfpe_host
`default_nettype wire

// [verif/sfpe_link_properties.sv]
// link timing and ownership assertions for the flash host/device connection
`default_nettype none
module sfpe_link_properties (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_oe
);
  logic sck_q;
  logic [7:0] rise_q;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
    end
  end
  // link clock rises since select, saturating on long frames
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rise_q <= 8'h00;
    end else if (cs_n) begin
      rise_q <= 8'h00;
    end else if (sck && !sck_q && rise_q != 8'hFF) begin
      rise_q <= rise_q + 8'h01;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sck_idle_a: assert property (cs_n |-> !sck) else $error("clock moved while deselected");
  frame_end_a: assert property ($rose(cs_n) |-> !rise_q[0] && rise_q >= 8'h02) else $error("bad frame end");
  data_start_a: assert property (|d_io_oe |-> rise_q >= 8'h0C) else $error("read data too early");
  dev_release_a: assert property (cs_n |-> d_io_oe == 4'h0) else $error("device drives deselected");
  no_clash_a: assert property ((h_io_oe & d_io_oe) == 4'h0) else $error("line contention");
  sck_high_a: assert property ($rose(sck) |=> sck ##1 !sck) else $error("clock high phase wrong");
  sck_low_a: assert property ($fell(sck) |=> !sck) else $error("clock low phase short");
  host_hold_a: assert property (sck && sck_q && |h_io_oe |-> $stable(h_io_o & h_io_oe))
    else $error("host data moved while clock high");
endmodule : sfpe_link_properties
`default_nettype wire

// [verif/serial_flash_program_erase_tb.sv]
// bench: host and device joined over the link, driven through the host request port
`default_nettype none
module serial_flash_program_erase_tb
  import sfpe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic quad_protocol_mode = 1'b0;
  logic qe = 1'b1;
  logic [3:0] prot = 4'h0;
  logic req = 1'b0;
  sfpe_op_type op = SFPE_OP_WRITE_ENABLE_CMD;
  logic [23:0] addr = 24'h000000;
  logic [8:0] len = 9'h001;
  logic [7:0] mode = 8'h00;
  logic skip = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic wr_take;
  logic rvalid;
  logic done;
  logic dbusy;
  logic hbusy;
  logic write_enable_latch;
  logic [7:0] rdata;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int fails = 0;
  int num_checks = 0;
  sfpe_if link ();
  sfpe_host i_sfpe_host (.CLOCK(clock), .NRST(nrst), .QPI_MODE(quad_protocol_mode), .DUMMY_CYCLES(4'h6), .REQ(req), .REQ_OP(op),
    .REQ_ADDR(addr), .REQ_LEN(len), .REQ_MODE(mode), .REQ_SKIP_OPC(skip), .WR_DATA(wdata), .WR_TAKE(wr_take),
    .RD_DATA(rdata), .RD_VALID(rvalid), .BUSY(hbusy), .DONE(done), .LINK(link.host));
  sfpe_device i_sfpe_device (.CLOCK(clock), .NRST(nrst), .QPI_MODE(quad_protocol_mode), .QUAD_ENABLE(qe), .BLOCK_PROTECT(prot),
    .DUMMY_CYCLES(4'h6), .BUSY(dbusy), .WRITE_ENABLE_LATCH(write_enable_latch), .LINK(link.dev));
  sfpe_link_properties i_sfpe_link_properties (.CLOCK(clock), .NRST(nrst), .sck(link.sck), .cs_n(link.cs_n),
    .h_io_o(link.h_io_o), .h_io_oe(link.h_io_oe), .d_io_oe(link.d_io_oe));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic final_report;
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  // one request, feeding write bytes and collecting read bytes until done
  task automatic xfer(input sfpe_op_type o, input logic [23:0] a, input logic [8:0] n, input logic [7:0] m,
                      input logic s);
    int k;
    int i;
    rq = {};
    i = 0;
    op = o;
    addr = a;
    len = n;
    mode = m;
    skip = s;
    wdata = wq[0];
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    for (k = 0; k < 20000; k++) begin
      @(negedge clock);
      if (wr_take === 1'b1 && i + 1 < wq.size()) begin
        i++;
        wdata = wq[i];
      end
      if (rvalid === 1'b1) rq.push_back(rdata);
      if (done === 1'b1) break;
    end
    if (k == 20000) begin
      fails++;
      final_report();
    end
    chk1(hbusy, 1'b0);
  endtask : xfer
  task automatic cmd(input sfpe_op_type o, input logic [23:0] a);
    xfer(o, a, 9'h001, 8'h00, 1'b0);
  endtask : cmd
  task automatic wait_idle;
    int k;
    for (k = 0; k < 70000 && dbusy !== 1'b0; k++) @(negedge clock);
    if (k == 70000) begin
      fails++;
      final_report();
    end
    repeat (16) @(negedge clock);
  endtask : wait_idle
  initial begin
    wq = {8'h00};
    for (int q = 0; q < 2; q++) begin
      nrst = 1'b0;
      quad_protocol_mode = q[0];
      repeat (6) @(negedge clock);
      nrst = 1'b1;
      repeat (2) @(negedge clock);
      if (q == 0) begin
        cmd(SFPE_OP_WRITE_ENABLE_CMD, 24'h000000);
        chk1(write_enable_latch, 1'b1);
        cmd(SFPE_OP_ERASE4, 24'h001234);
        chk1(dbusy, 1'b1);
        xfer(SFPE_OP_READ, 24'h000000, 9'h001, 8'h00, 1'b0);
        chk8(rq[0], 8'hFF);
        cmd(SFPE_OP_PROG, 24'h001010);
        wait_idle();
        chk1(write_enable_latch, 1'b0);
      end
      prot = 4'hF;
      cmd(SFPE_OP_WRITE_ENABLE_CMD, 24'h000000);
      cmd(SFPE_OP_PROG, 24'h0010FE);
      wait_idle();
      chk1(write_enable_latch, 1'b1);
      prot = 4'h0;
      qe = 1'b0;
      cmd(SFPE_OP_QPROG, 24'h0010FE);
      wait_idle();
      chk1(write_enable_latch, 1'b1);
      qe = 1'b1;
      wq = {8'h11, 8'h22, 8'h33, 8'h44};
      xfer(SFPE_OP_PROG, 24'h0010FE, 9'h004, 8'h00, 1'b0);
      wait_idle();
      chk1(write_enable_latch, 1'b0);
      wq = {8'h0F};
      cmd(SFPE_OP_WRITE_ENABLE_CMD, 24'h000000);
      cmd(SFPE_OP_QPROG, 24'h0010FE);
      wait_idle();
      xfer(SFPE_OP_READ, 24'h0010FE, 9'h004, 8'hA5, 1'b0);
      chk8(rq[0], 8'h01);
      chk8(rq[1], 8'h22);
      chk8(rq[2], 8'hFF);
      xfer(SFPE_OP_READ, 24'h001000, 9'h002, 8'h0F, 1'b1);
      chk8(rq[0], 8'h33);
      chk8(rq[1], 8'h44);
      xfer(SFPE_OP_READ, 24'h001010, 9'h001, 8'h00, 1'b0);
      chk8(rq[0], 8'hFF);
      cmd(SFPE_OP_WRITE_ENABLE_CMD, 24'h000000);
      cmd(q == 0 ? SFPE_OP_ERASE32 : SFPE_OP_ERASE64, q == 0 ? 24'h005678 : 24'h00ABCD);
      wait_idle();
      xfer(SFPE_OP_READ, 24'h0010FE, 9'h002, 8'h00, 1'b0);
      chk8(rq[0], 8'hFF);
      chk8(rq[1], 8'hFF);
      wq = {8'h00};
    end
    final_report();
  end
endmodule : serial_flash_program_erase_tb
`default_nettype wire
